/* File: logic/pc_stack.sv */
// Program counter sequencing with an eight-entry circular return stack
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module pc_stack (
    // Clock, reset, enable
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // Sequencing from the decoder and interrupt logic
    input  wire logic        step_i,
    input  wire logic        call_i,
    input  wire logic        jump_i,
    input  wire logic        ret_i,
    input  wire logic        int_branch_i,
    input  wire logic [10:0] lit_addr_i,
    // Program counter
    output logic      [12:0] pc_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [12:0] pc_q;
    logic [12:0] pc_d;
    logic [4:0]  latch_q;
    logic [2:0]  sp_q;
    logic [2:0]  sp_d;
    logic [12:0] stack_q [8];
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire         sel_pcl   = reg_addr_i[6:0] == pc_stack_pkg::PCL_OFF;
    wire         sel_latch = reg_addr_i[6:0] == pc_stack_pkg::LATCH_OFF;
    wire         wr_pcl    = reg_wr_i && sel_pcl;
    wire         wr_latch  = reg_wr_i && sel_latch;
    wire         do_push   = call_i || int_branch_i;
    wire         do_pop    = ret_i && !do_push;
    wire [12:0]  pc_next   = pc_q + 13'h0001;
    wire [2:0]   sp_top    = sp_q - 3'h1;
    // Paging bits pass into the PC but single-page memory ignores them
    wire [12:0]  branch_pc = {latch_q[4:3], lit_addr_i};

    // ------------------------------------------------------------
    // Next state: interrupt over call over return over jump
    // ------------------------------------------------------------
    always_comb begin
        pc_d = pc_q;
        sp_d = sp_q;
        if (int_branch_i) begin
            pc_d = pc_stack_pkg::INT_VEC;
            sp_d = sp_q + 3'h1;
        end else if (call_i) begin
            pc_d = branch_pc;
            sp_d = sp_q + 3'h1;
        end else if (do_pop) begin
            pc_d = stack_q[sp_top];
            sp_d = sp_top;
        end else if (jump_i) begin
            pc_d = branch_pc;
        end else if (wr_pcl) begin
            pc_d = {latch_q, reg_wdata_i};
        end else if (step_i) begin
            pc_d = pc_next;
        end
    end

    // Upper PC bits are never on the read mux
    assign rdata_d = sel_pcl   ? pc_q[7:0] :
                     sel_latch ? {3'h0, latch_q} :
                                 8'h00;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pc_q    <= pc_stack_pkg::RST_VEC;
            sp_q    <= 3'h0;
            latch_q <= pc_stack_pkg::LATCH_RST;
            rdata_q <= 8'h00;
        end else if (ce_i) begin
            pc_q    <= pc_d;
            sp_q    <= sp_d;
            rdata_q <= reg_rd_i ? rdata_d : 8'h00;
            if (wr_latch) begin
                latch_q <= reg_wdata_i[4:0];
            end
        end
    end

    // Stack entries: pushed value is the next instruction address
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_stack
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    stack_q[gi] <= 13'h0000;
                end else if (ce_i && do_push && sp_q == 3'(gi)) begin
                    stack_q[gi] <= pc_next;
                end
            end
        end
    endgenerate

    assign reg_rdata_o = rdata_q;
    assign pc_o        = pc_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Qualified events, following the sequencing priority
    wire branch_taken = ce_i && !int_branch_i &&
                        (call_i || (jump_i && !ret_i));
    wire pop_taken    = ce_i && ret_i && !call_i && !int_branch_i;
    wire no_op        = !step_i && !call_i && !jump_i && !ret_i &&
                        !int_branch_i && !wr_pcl;

    // ------------------------------------------------------------
    // Checks on reset
    // ------------------------------------------------------------
    chk_reset_zero: assert property (
        @(posedge mclk_i)
        rst_i |=> pc_o == pc_stack_pkg::RST_VEC && latch_q == 5'h00)
        else $error("reset did not clear pc");

    chk_reset_latch: assert property (
        @(posedge mclk_i)
        rst_i |=> latch_q == pc_stack_pkg::LATCH_RST)
        else $error("reset did not clear latch");

    chk_reset_pointer: assert property (
        @(posedge mclk_i)
        rst_i |=> sp_q == 3'h0)
        else $error("reset did not clear stack pointer");

    chk_reset_rdata: assert property (
        @(posedge mclk_i)
        rst_i |=> reg_rdata_o == 8'h00)
        else $error("reset did not clear read data");

    // ------------------------------------------------------------
    // Checks on the register port, stepping and idle hold
    // ------------------------------------------------------------
    chk_pcl_write_load: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && wr_pcl && !call_i && !jump_i && !ret_i && !int_branch_i
        |=> pc_o == {$past(latch_q), $past(reg_wdata_i)})
        else $error("low byte write did not load full latch");

    chk_pcl_read: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && reg_rd_i && sel_pcl
        |=> reg_rdata_o == $past(pc_o[7:0]))
        else $error("low byte read wrong");

    chk_latch_read: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && reg_rd_i && sel_latch |=> reg_rdata_o[7:5] == 3'h0)
        else $error("latch top bits not zero");

    chk_latch_value: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && reg_rd_i && sel_latch
        |=> reg_rdata_o[4:0] == $past(latch_q))
        else $error("latch read value wrong");

    chk_latch_write: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && wr_latch |=> latch_q == $past(reg_wdata_i[4:0]))
        else $error("latch write lost");

    chk_latch_hold: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !(ce_i && wr_latch) |=> $stable(latch_q))
        else $error("latch changed without a write");

    chk_bank_mirror: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && reg_rd_i && reg_addr_i[6:0] == 7'h0A
        |=> reg_rdata_o == {3'h0, $past(latch_q)})
        else $error("latch not seen from both banks");

    chk_unmapped_read: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && reg_rd_i && !sel_pcl && !sel_latch
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");

    chk_rdata_idle: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data stood past its cycle");

    chk_step_advance: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && step_i && !call_i && !jump_i && !ret_i && !int_branch_i
        && !wr_pcl |=> pc_o == $past(pc_o) + 13'h0001)
        else $error("step did not advance pc");

    chk_idle_hold: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && no_op |=> $stable(pc_o))
        else $error("pc moved with no request");

    // ------------------------------------------------------------
    // Checks on branches
    // ------------------------------------------------------------
    chk_branch_load: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        branch_taken
        |=> pc_o == {$past(latch_q[4:3]), $past(lit_addr_i)})
        else $error("call or jump target wrong");

    chk_branch_low: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        branch_taken |=> pc_o[10:0] == $past(lit_addr_i))
        else $error("branch low bits not from literal");

    chk_branch_page: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        branch_taken |=> pc_o[12:11] == $past(latch_q[4:3]))
        else $error("paging bits not passed through");

    chk_int_vector: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && int_branch_i |=> pc_o == pc_stack_pkg::INT_VEC)
        else $error("interrupt did not vector to 0004h");

    chk_int_push: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && int_branch_i
        |=> stack_q[$past(sp_q)] == $past(pc_o) + 13'h0001)
        else $error("interrupt did not push return address");

    chk_call_push: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && call_i && !int_branch_i
        |=> stack_q[$past(sp_q)] == $past(pc_o) + 13'h0001)
        else $error("call did not push next address");

    // ------------------------------------------------------------
    // Checks on the return stack, latch hold and enable freeze
    // ------------------------------------------------------------
    chk_call_return: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && call_i && !int_branch_i ##1 pop_taken
        |=> pc_o == $past(pc_o, 2) + 13'h0001)
        else $error("return address not next instruction");

    chk_latch_stable: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (do_push || ret_i) && !wr_latch |=> $stable(latch_q))
        else $error("latch changed on push or pop");

    chk_stack_wrap: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && do_push |=> sp_q == $past(sp_q) + 3'h1)
        else $error("stack pointer did not advance");

    chk_pop_pointer: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        pop_taken |=> sp_q == $past(sp_q) - 3'h1)
        else $error("stack pointer did not retreat");

    chk_pop_value: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        pop_taken |=> pc_o == $past(stack_q[sp_top]))
        else $error("return did not load top entry");

    chk_pointer_hold: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !do_push && !ret_i |=> $stable(sp_q))
        else $error("stack pointer moved without push or pop");

    chk_jump_no_push: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && jump_i && !call_i && !ret_i && !int_branch_i
        |=> sp_q == $past(sp_q))
        else $error("jump touched the stack");

    chk_enable_freeze: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !ce_i |=> $stable(pc_o) && $stable(sp_q) && $stable(latch_q)
        && $stable(reg_rdata_o))
        else $error("state moved with enable low");
endmodule : pc_stack

/* File: shared/pc_stack_pkg.sv */
// Constants for the program counter and return stack block
package pc_stack_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned PC_W      = 13;
    localparam int unsigned DEPTH     = 8;
    localparam int unsigned SP_W      = 3;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned LIT_W     = 11;
    localparam int unsigned UPPER_W   = 5;
    // ------------------------------------------------------------
    // Register offsets, bank bit is ignored on decode
    // ------------------------------------------------------------
    localparam logic [6:0] PCL_OFF    = 7'h02;
    localparam logic [6:0] LATCH_OFF  = 7'h0A;
    // ------------------------------------------------------------
    // Reset values and vectors
    // ------------------------------------------------------------
    localparam logic [7:0]  PCL_RST   = 8'h00;
    localparam logic [4:0]  LATCH_RST = 5'h00;
    localparam logic [12:0] RST_VEC   = 13'h0000;
    localparam logic [12:0] INT_VEC   = 13'h0004;
    // Paging field position inside the latch
    localparam int unsigned PAGE_LSB  = 3;
endpackage : pc_stack_pkg

/* File: tb/core_decoder_model.sv */
// Model of the instruction decoder and interrupt logic
`timescale 1ns/1ps
module core_decoder_model (
    // Command from the bench
    input  wire logic [2:0]  op_i,
    input  wire logic [10:0] lit_i,
    // Sequencing pulses
    output logic             step_o,
    output logic             call_o,
    output logic             jump_o,
    output logic             ret_o,
    output logic             int_branch_o,
    output logic      [10:0] lit_addr_o
);
    assign step_o       = (op_i == 3'h1);
    assign call_o       = (op_i == 3'h2);
    assign jump_o       = (op_i == 3'h3);
    assign ret_o        = (op_i == 3'h4);
    assign int_branch_o = (op_i == 3'h5);
    // Literal is stale outside a call or jump, so show its inverse
    assign lit_addr_o   = (call_o | jump_o) ? lit_i : ~lit_i;
endmodule : core_decoder_model

/* File: tb/program_counter_return_stack_tb_top.sv */
// Self-checking bench for the program counter and return stack
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module program_counter_return_stack_tb_top;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [2:0]  op = 3'h0;
    logic [10:0] lit = 11'h000, lit_addr;
    logic        step, call, jump, ret, intb;
    logic [12:0] pc, exp_pc;
    logic [12:0] pushed [9];
    int          fails = 0, n_compared = 0, cyc = 0;
    initial forever #2 mclk_i = ~mclk_i;
    core_decoder_model u_core (.op_i(op), .lit_i(lit), .step_o(step),
        .call_o(call), .jump_o(jump), .ret_o(ret), .int_branch_o(intb),
        .lit_addr_o(lit_addr));
    pc_stack u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .step_i(step), .call_i(call),
        .jump_i(jump), .ret_i(ret), .int_branch_i(intb),
        .lit_addr_i(lit_addr), .pc_o(pc));
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge mclk_i);
        wr    <= w;
        rd    <= ~w;
        addr  <= a;
        wdata <= d;
        @(posedge mclk_i);
        wr    <= 1'b0;
        rd    <= 1'b0;
        #1;
    endtask : acc
    task automatic do_op(input logic [2:0] c, input logic [10:0] l);
        @(posedge mclk_i);
        op  <= c;
        lit <= l;
        @(posedge mclk_i);
        op  <= 3'h0;
        #1;
    endtask : do_op
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1;
        `CHK(pc, 13'h0000)
        acc(1'b0, 8'h02, 8'h00);
        `CHK(rdata, 8'h00)
        acc(1'b0, 8'h07, 8'h00);
        `CHK(rdata, 8'h00)
        acc(1'b1, 8'h0A, 8'hFF);
        acc(1'b0, 8'h8A, 8'h00);
        `CHK(rdata, 8'h1F)
        acc(1'b1, 8'h82, 8'h40);
        `CHK(pc, 13'h1F40)
        do_op(3'h1, 11'h000);
        acc(1'b0, 8'h02, 8'h00);
        `CHK(rdata, 8'h41)
        do_op(3'h2, 11'h123);
        `CHK(pc, 13'h1923)
        do_op(3'h5, 11'h000);
        `CHK(pc, 13'h0004)
        acc(1'b0, 8'h0A, 8'h00);
        `CHK(rdata, 8'h1F)
        do_op(3'h4, 11'h000);
        `CHK(pc, 13'h1924)
        do_op(3'h4, 11'h000);
        `CHK(pc, 13'h1F42)
        acc(1'b1, 8'h0A, 8'h08);
        do_op(3'h3, 11'h7FF);
        `CHK(pc, 13'h0FFF)
        acc(1'b1, 8'h0A, 8'h00);
        exp_pc = 13'h0FFF;
        for (int i = 0; i < 9; i++) begin
            pushed[i] = exp_pc + 13'h0001;
            exp_pc = {2'b00, 11'h100 + 11'(i)};
            do_op(3'h2, exp_pc[10:0]);
        end
        for (int i = 8; i >= 0; i--) begin
            do_op(3'h4, 11'h000);
            `CHK(pc, pushed[(i == 0) ? 8 : i])
        end
        acc(1'b1, 8'h0A, 8'h01);
        acc(1'b1, 8'h02, 8'hFF);
        acc(1'b1, 8'h0A, 8'h02);
        acc(1'b1, 8'h02, 8'h05);
        `CHK(pc, 13'h0205)
        @(posedge mclk_i);
        ce <= 1'b0;
        do_op(3'h1, 11'h000);
        `CHK(pc, 13'h0205)
        @(posedge mclk_i);
        ce    <= 1'b1;
        rst_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        `CHK(pc, 13'h0000)
        @(posedge mclk_i);
        rst_i <= 1'b0;
        acc(1'b0, 8'h0A, 8'h00);
        `CHK(rdata, 8'h00)
        summarize();
    end
endmodule : program_counter_return_stack_tb_top
